// ==== core/sft_serial_port.v ====
// serial port: register slave, rate generation, transmit path and frame receiver
//
// Notes on behaviour
// - all thirty formats: five to nine data bits, parity options, one or two stops
// - start bit first, then data bits least significant first
// - parity bit sits after last data bit, before first stop bit
// - next frame may follow at once, else line idles high
// - one shared format setting for receiver and transmitter
// - format changes mid-frame corrupt traffic; no protection provided
// - receiver checks only first stop bit; frame error when it is zero
// - parity is xor of data bits, inverted for odd parity
// - two-bit parity mode field; one stop select bit
// - transmit enable hands the transmit pin to the port
// - sync master mode with transmitter on takes over the clock pin
// - data port write loads transmit buffer and starts sending
// - buffer moves to shifter when idle or right after last stop bit
// - loaded shifter sends one frame at divisor, double speed or pin rate
// - unused upper data bits are ignored for short characters
// - receive complete flag shows unread data in receive buffer
// - buffer empty flag clears on data write, sets on move to shifter
// - transmit complete sets after frame with nothing waiting; write one clears
`timescale 1ns/10ps
`default_nettype none
`include "sft_defines.vh"
module sft_serial_port (
  input wire clk,
  input wire reset,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output wire txd_out,
  output reg txd_oe,
  input wire rxd_in,
  input wire sync_clock_pin_in,
  output reg sync_clock_pin_out,
  output reg sync_clock_pin_oe
);
  // size code to data bit count; reserved codes fall back to eight
  function [3:0] data_bits_of;
    input [2:0] code;
    begin
      case (code)
        3'h0: data_bits_of = 4'h5;
        3'h1: data_bits_of = 4'h6;
        3'h2: data_bits_of = 4'h7;
        `SFT_CSZ_NINE: data_bits_of = 4'h9;
        default: data_bits_of = 4'h8;
      endcase
    end
  endfunction

  // reset image of control_reg_c, sliced per field so widths stay exact
  localparam [7:0] rst_ctrl_c = `SFT_RST_CTRL_C;

  // software-visible settings
  reg [2:0] char_size_sel;
  reg [1:0] parity_mode_sel;
  reg stop_bits_sel;
  reg transmit_enable_bit;
  reg rx_enable;
  reg tx_ninth_bit;
  reg double_speed_bit;
  reg sync_mode;
  reg sync_master;
  reg clock_pol;
  reg [11:0] baud_divisor;
  // transmit side state
  reg [8:0] tx_buffer;
  reg tx_buffer_empty_flag;
  reg tx_complete_flag;
  // receive side state
  reg [8:0] rx_buffer;
  reg rx_complete_flag;
  reg frame_error_flag;
  reg rx_busy;
  reg [3:0] rx_idx;
  reg [3:0] rx_os;
  reg [8:0] rx_shift;
  // rate generation
  reg [11:0] baud_cnt;
  reg os_tick;
  reg [3:0] tx_pre;
  // pin synchronisers
  reg rxd_s1;
  reg rxd_s2;
  reg xck_s1;
  reg xck_s2;
  reg xck_s3;

  wire [3:0] n_bits, os_last, os_mid, par_idx, stop_idx;
  wire bus_req, bus_take, wr_data, rd_data;
  wire wr_status, wr_ctrl_b, wr_ctrl_c, wr_baud;
  wire xck_rise, xck_fall, sync_change, sync_sample;
  wire tx_tick, rx_sample, tx_ready, tx_busy, tx_done, tx_move;

  // one format drives both directions
  assign n_bits = data_bits_of(char_size_sel);
  assign os_last = double_speed_bit ? `SFT_OS_DOUBLE : `SFT_OS_NORMAL;
  assign os_mid = double_speed_bit ? `SFT_MID_DOUBLE : `SFT_MID_NORMAL;

  // bus decode; an access takes effect on the edge where waitrequest is low
  assign bus_req = avs_read | avs_write;
  assign bus_take = bus_req & ~avs_waitrequest;
  assign wr_data = bus_take & avs_write & avs_byteenable[0] &
    (avs_address == `SFT_ADDR_DATA);
  assign rd_data = bus_take & avs_read & (avs_address == `SFT_ADDR_DATA);
  assign wr_status = bus_take & avs_write & avs_byteenable[0] &
    (avs_address == `SFT_ADDR_STATUS);
  assign wr_ctrl_b = bus_take & avs_write & avs_byteenable[0] &
    (avs_address == `SFT_ADDR_CTRL_B);
  assign wr_ctrl_c = bus_take & avs_write & avs_byteenable[0] &
    (avs_address == `SFT_ADDR_CTRL_C);
  assign wr_baud = bus_take & avs_write & (avs_address == `SFT_ADDR_BAUD);

  // one wait state per access, so every answer comes from registers
  always @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // read data captured as waitrequest drops; unmapped reads give zero
  always @(posedge clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        `SFT_ADDR_DATA: avs_readdata <= {24'h0, rx_buffer[7:0]};
        `SFT_ADDR_STATUS: avs_readdata <= {24'h0, rx_complete_flag, tx_complete_flag,
          tx_buffer_empty_flag, frame_error_flag, 2'h0, double_speed_bit, 1'b0};
        `SFT_ADDR_CTRL_B: avs_readdata <= {27'h0, rx_enable, transmit_enable_bit,
          char_size_sel[2], rx_buffer[8], tx_ninth_bit};
        `SFT_ADDR_CTRL_C: avs_readdata <= {24'h0, sync_master, sync_mode,
          parity_mode_sel, stop_bits_sel, char_size_sel[1:0], clock_pol};
        `SFT_ADDR_BAUD: avs_readdata <= {20'h0, baud_divisor};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // control fields; changing format mid-frame is not guarded against
  always @(posedge clk) begin
    if (reset) begin
      char_size_sel <= {1'b0, rst_ctrl_c[`SFT_CC_CSZ_HI:`SFT_CC_CSZ_LO]};
      parity_mode_sel <= 2'h0;
      stop_bits_sel <= 1'b0;
      transmit_enable_bit <= 1'b0;
      rx_enable <= 1'b0;
      tx_ninth_bit <= 1'b0;
      double_speed_bit <= 1'b0;
      sync_mode <= 1'b0;
      sync_master <= 1'b0;
      clock_pol <= 1'b0;
      baud_divisor <= `SFT_RST_BAUD;
    end else begin
      if (wr_status) begin
        double_speed_bit <= avs_writedata[`SFT_ST_DBL];
      end
      if (wr_ctrl_b) begin
        rx_enable <= avs_writedata[`SFT_CB_RXEN];
        transmit_enable_bit <= avs_writedata[`SFT_CB_TXEN];
        char_size_sel[2] <= avs_writedata[`SFT_CB_CSZ2];
        tx_ninth_bit <= avs_writedata[`SFT_CB_TX9];
      end
      if (wr_ctrl_c) begin
        sync_master <= avs_writedata[`SFT_CC_MASTER];
        sync_mode <= avs_writedata[`SFT_CC_SYNC];
        parity_mode_sel <= avs_writedata[`SFT_CC_PAR_HI:`SFT_CC_PAR_LO];
        stop_bits_sel <= avs_writedata[`SFT_CC_STOP];
        char_size_sel[1:0] <= avs_writedata[`SFT_CC_CSZ_HI:`SFT_CC_CSZ_LO];
        clock_pol <= avs_writedata[`SFT_CC_POL];
      end
      if (wr_baud && avs_byteenable[0]) begin
        baud_divisor[7:0] <= avs_writedata[7:0];
      end
      if (wr_baud && avs_byteenable[1]) begin
        baud_divisor[11:8] <= avs_writedata[11:8];
      end
    end
  end

  // baud down-counter, reloaded at zero and on a divisor write
  always @(posedge clk) begin
    if (reset) begin
      baud_cnt <= `SFT_RST_BAUD;
      os_tick <= 1'b0;
    end else if (wr_baud) begin
      baud_cnt <= baud_divisor;
      os_tick <= 1'b0;
    end else if (baud_cnt == 12'h000) begin
      baud_cnt <= baud_divisor;
      os_tick <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt - 12'h001;
      os_tick <= 1'b0;
    end
  end

  // transmit prescaler: sixteen or eight oversample ticks per bit
  always @(posedge clk) begin
    if (reset) begin
      tx_pre <= 4'h0;
    end else if (os_tick) begin
      tx_pre <= (tx_pre >= os_last) ? 4'h0 : tx_pre + 4'h1;
    end
  end

  // pin synchronisers; rxd is read from the second stage, the clock pin from the second and third
  always @(posedge clk) begin
    if (reset) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      xck_s1 <= 1'b0;
      xck_s2 <= 1'b0;
      xck_s3 <= 1'b0;
    end else begin
      rxd_s1 <= rxd_in;
      rxd_s2 <= rxd_s1;
      xck_s1 <= sync_clock_pin_in;
      xck_s2 <= xck_s1;
      xck_s3 <= xck_s2;
    end
  end

  // master clock toggles per oversample tick; pin driven only with tx on
  always @(posedge clk) begin
    if (reset) begin
      sync_clock_pin_out <= 1'b0;
      sync_clock_pin_oe <= 1'b0;
    end else begin
      sync_clock_pin_oe <= sync_mode & sync_master & txd_oe;
      if (!(sync_mode && sync_master)) begin
        sync_clock_pin_out <= clock_pol;
      end else if (os_tick) begin
        sync_clock_pin_out <= ~sync_clock_pin_out;
      end
    end
  end

  // data changes on one clock edge and is sampled on the other
  assign xck_rise = xck_s2 & ~xck_s3;
  assign xck_fall = ~xck_s2 & xck_s3;
  assign sync_change = sync_master ? (os_tick & (sync_clock_pin_out == clock_pol)) :
    (clock_pol ? xck_fall : xck_rise);
  assign sync_sample = sync_master ? (os_tick & (sync_clock_pin_out != clock_pol)) :
    (clock_pol ? xck_rise : xck_fall);
  assign tx_tick = sync_mode ? sync_change : (os_tick & (tx_pre == os_last));
  assign rx_sample = sync_mode ? sync_sample : (os_tick & (rx_os == os_mid));

  // buffer empties into the shifter whenever the shifter can take it and txd_oe is set
  assign tx_move = ~tx_buffer_empty_flag & tx_ready & txd_oe;

  sft_tx_shift u_shift (
    .clk(clk),
    .reset(reset),
    .bit_tick(tx_tick),
    .load(tx_move),
    .load_data(tx_buffer),
    .data_bits(n_bits),
    .parity_mode(parity_mode_sel),
    .two_stop(stop_bits_sel),
    .ready(tx_ready),
    .busy(tx_busy),
    .ser_out(txd_out),
    .frame_done(tx_done)
  );

  // pin stays with the port until pending and ongoing frames are out
  always @(posedge clk) begin
    if (reset) begin
      txd_oe <= 1'b0;
    end else begin
      txd_oe <= transmit_enable_bit | (txd_oe & (tx_busy | ~tx_buffer_empty_flag));
    end
  end

  // transmit buffer and its flags; a write in the move cycle keeps the new byte
  always @(posedge clk) begin
    if (reset) begin
      tx_buffer <= 9'h000;
      tx_buffer_empty_flag <= 1'b1;
      tx_complete_flag <= 1'b0;
    end else begin
      if (wr_data) begin
        tx_buffer <= {tx_ninth_bit, avs_writedata[7:0]};
        tx_buffer_empty_flag <= 1'b0;
      end else if (tx_move) begin
        tx_buffer_empty_flag <= 1'b1;
      end
      // set wins over a write-one clear in the same cycle
      if (tx_done) begin
        tx_complete_flag <= 1'b1;
      end else if (wr_status && avs_writedata[`SFT_ST_TXC]) begin
        tx_complete_flag <= 1'b0;
      end
    end
  end

  assign par_idx = n_bits + 4'h1;
  assign stop_idx = n_bits + 4'h1 + {3'h0, parity_mode_sel[1]};

  // frame receiver: start, data, optional parity, first stop only
  always @(posedge clk) begin
    if (reset) begin
      rx_busy <= 1'b0;
      rx_idx <= 4'h0;
      rx_os <= 4'h0;
      rx_shift <= 9'h000;
      rx_buffer <= 9'h000;
      rx_complete_flag <= 1'b0;
      frame_error_flag <= 1'b0;
    end else begin
      if (os_tick) begin
        rx_os <= (rx_os >= os_last) ? 4'h0 : rx_os + 4'h1;
      end
      if (rd_data || !rx_enable) begin
        rx_complete_flag <= 1'b0;
      end
      if (!rx_enable) begin
        rx_busy <= 1'b0;
      end else if (!rx_busy) begin
        if (!sync_mode && !rxd_s2) begin
          rx_busy <= 1'b1;
          rx_idx <= 4'h0;
          rx_os <= 4'h0;
        end else if (sync_mode && sync_sample && !rxd_s2) begin
          rx_busy <= 1'b1;
          rx_idx <= 4'h1;
        end
      end else if (rx_sample) begin
        rx_idx <= rx_idx + 4'h1;
        if (rx_idx == 4'h0) begin
          rx_busy <= ~rxd_s2;
        end else if (rx_idx <= n_bits) begin
          rx_shift <= {rxd_s2, rx_shift[8:1]};
        end else if (rx_idx == stop_idx) begin
          // second stop bit is never looked at
          rx_busy <= 1'b0;
          rx_buffer <= rx_shift >> (4'h9 - n_bits);
          frame_error_flag <= ~rxd_s2;
          rx_complete_flag <= 1'b1;
        end else if (rx_idx != par_idx) begin
          rx_busy <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== include/sft_defines.vh ====
// register map, field positions, reset values and rate constants of the serial port
`ifndef SFT_DEFINES_VH
`define SFT_DEFINES_VH
// byte addresses on the register bus
`define SFT_ADDR_DATA 5'h00
`define SFT_ADDR_STATUS 5'h04
`define SFT_ADDR_CTRL_B 5'h08
`define SFT_ADDR_CTRL_C 5'h0c
`define SFT_ADDR_BAUD 5'h10
// status register bits
`define SFT_ST_RXC 7
`define SFT_ST_TXC 6
`define SFT_ST_TBE 5
`define SFT_ST_FE 4
`define SFT_ST_DBL 1
// control_reg_b bits
`define SFT_CB_RXEN 4
`define SFT_CB_TXEN 3
`define SFT_CB_CSZ2 2
`define SFT_CB_RX9 1
`define SFT_CB_TX9 0
// control_reg_c bits
`define SFT_CC_MASTER 7
`define SFT_CC_SYNC 6
`define SFT_CC_PAR_HI 5
`define SFT_CC_PAR_LO 4
`define SFT_CC_STOP 3
`define SFT_CC_CSZ_HI 2
`define SFT_CC_CSZ_LO 1
`define SFT_CC_POL 0
// reset values
`define SFT_RST_CTRL_C 8'h06
`define SFT_RST_BAUD 12'h000
// oversample ticks per bit, normal and double speed
`define SFT_OS_NORMAL 4'hf
`define SFT_OS_DOUBLE 4'h7
`define SFT_MID_NORMAL 4'h7
`define SFT_MID_DOUBLE 4'h3
// character size code for nine data bits
`define SFT_CSZ_NINE 3'h7
`endif

// ==== core/sft_tx_shift.v ====
// transmit shift register: builds and sends one serial frame
`timescale 1ns/10ps
`default_nettype none
module sft_tx_shift (
  input wire clk,
  input wire reset,
  input wire bit_tick,
  input wire load,
  input wire [8:0] load_data,
  input wire [3:0] data_bits,
  input wire [1:0] parity_mode,
  input wire two_stop,
  output wire ready,
  output reg busy,
  output reg ser_out,
  output reg frame_done
);
  reg [12:0] shreg;
  reg [3:0] cnt;
  reg [12:0] frame;
  reg [3:0] nbits;
  reg par;
  integer i;

  // frame image, lsb goes out first; unused upper data bits never enter it
  always @* begin
    frame = 13'h1fff;
    par = parity_mode[0];
    frame[0] = 1'b0;
    for (i = 0; i < 9; i = i + 1) begin
      if (i < data_bits) begin
        frame[i + 1] = load_data[i];
        par = par ^ load_data[i];
      end
    end
    if (parity_mode[1]) begin
      frame[data_bits + 4'h1] = par;
    end
    nbits = data_bits + 4'h2 + {3'h0, parity_mode[1]} + {3'h0, two_stop};
  end

  // a load on the tick that ends the last stop bit starts the next frame at once
  assign ready = !busy || (bit_tick && cnt == 4'h0);

  // one bit per tick; line rests high between frames
  always @(posedge clk) begin
    if (reset) begin
      busy <= 1'b0;
      ser_out <= 1'b1;
      shreg <= 13'h1fff;
      cnt <= 4'h0;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (load) begin
        busy <= 1'b1;
        if (bit_tick) begin
          ser_out <= frame[0];
          shreg <= {1'b1, frame[12:1]};
          cnt <= nbits - 4'h1;
        end else begin
          shreg <= frame;
          cnt <= nbits;
        end
      end else if (busy && bit_tick) begin
        if (cnt != 4'h0) begin
          ser_out <= shreg[0];
          shreg <= {1'b1, shreg[12:1]};
          cnt <= cnt - 4'h1;
        end else begin
          busy <= 1'b0;
          ser_out <= 1'b1;
          frame_done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/sft_serial_port_props.sv ====
// assertion checker for the serial port bus slave and transmit pin
`timescale 1ns/10ps
`default_nettype none
`include "sft_defines.vh"
module sft_serial_port_props (
  input wire clk,
  input wire reset,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire txd_out,
  input wire txd_oe,
  input wire rxd_in,
  input wire sync_clock_pin_in,
  input wire sync_clock_pin_out,
  input wire sync_clock_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // decoded access phases; the map is word aligned up to the baud register
  wire req = avs_read | avs_write;
  wire rd_done = avs_read & ~avs_waitrequest;
  wire mapped = (avs_address[1:0] == 2'h0) && (avs_address <= `SFT_ADDR_BAUD);
  wire txen_wr = avs_write & ~avs_waitrequest & avs_byteenable[0] & avs_writedata[3];
  property p_wait_one;
    req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("no answer after one wait");
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long");
  property p_unmapped;
    rd_done && !mapped |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status_bits;
    rd_done && avs_address == `SFT_ADDR_STATUS |-> (avs_readdata & 32'hffffff0d) == 32'h0;
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status spare bits set");
  property p_rd_hold;
    $changed(avs_readdata) |-> rd_done;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_oe_on;
    txen_wr && avs_address == `SFT_ADDR_CTRL_B |-> ##[1:2] txd_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin not taken");
  property p_oe_idle;
    $rose(txd_oe) |-> txd_out;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("pin not idle high");
  property p_start;
    $fell(txd_out) && txd_oe |-> !txd_out [*8];
  endproperty
  a_start: assert property (p_start) else $error("start bit too short");
  // main scenarios
  c_data_wr: cover property (avs_write && !avs_waitrequest && avs_address == `SFT_ADDR_DATA);
  c_frame: cover property ($fell(txd_out) && txd_oe);
  c_enable: cover property ($rose(txd_oe));
endmodule
bind sft_serial_port sft_serial_port_props u_props (
  .clk(clk),
  .reset(reset),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .txd_out(txd_out),
  .txd_oe(txd_oe),
  .rxd_in(rxd_in),
  .sync_clock_pin_in(sync_clock_pin_in),
  .sync_clock_pin_out(sync_clock_pin_out),
  .sync_clock_pin_oe(sync_clock_pin_oe)
);
`default_nettype wire

// ==== tb/sft_peer.sv ====
// remote serial peer: samples frames from the transmit line mid-bit
`timescale 1ns/10ps
`default_nettype none
module sft_peer #(
  parameter int BIT = 16
) (
  input wire logic clk,
  input wire logic txd,
  input wire logic oe,
  input wire logic [3:0] len,
  input wire logic fast,
  output wire logic rxd,
  output var logic [11:0] bits,
  output var int count
);
  logic prev;
  int step;
  // own line stays at its idle level; it never sends to the port
  assign rxd = 1'b1;
  // sample on the falling clock so registered line changes have settled
  initial begin
    bits = 12'h000;
    count = 0;
    prev = 1'b1;
    forever begin
      @(negedge clk);
      if (oe && prev && !txd) begin
        bits = 12'h000;
        // double speed halves the bit period
        step = fast ? BIT / 2 : BIT;
        repeat (step / 2) @(negedge clk);
        for (int i = 0; i < len; i++) begin
          repeat (step) @(negedge clk);
          bits[i] = txd;
        end
        count++;
      end
      prev = txd;
    end
  end
endmodule
`default_nettype wire

// ==== tb/test_serial_frame_format_transmitter.sv ====
// self-checking bench: register access, all frame formats, transmit flags
`timescale 1ns/10ps
`default_nettype none
`include "sft_defines.vh"
module test_serial_frame_format_transmitter;
  logic clk, reset, avs_read, avs_write, avs_waitrequest, txd_out, txd_oe, rxd_in;
  logic fast, sync_clock_pin_out, sync_clock_pin_oe;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] len;
  logic [11:0] bits;
  int count, err_count, comparisons, n, c0;
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  logic [1:0] pms [3] = '{2'b00, 2'b10, 2'b11};
  logic [4:0] ra [5] = '{5'h04, 5'h08, 5'h0c, 5'h10, 5'h14};
  logic [31:0] rv [5] = '{32'h20, 32'h0, 32'h06, 32'h0, 32'h0};
  sft_serial_port dut (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .txd_out(txd_out),
    .txd_oe(txd_oe), .rxd_in(rxd_in), .sync_clock_pin_in(1'b0),
    .sync_clock_pin_out(sync_clock_pin_out), .sync_clock_pin_oe(sync_clock_pin_oe)
  );
  sft_peer peer (
    .clk(clk), .txd(txd_out), .oe(txd_oe), .len(len), .fast(fast), .rxd(rxd_in), .bits(bits),
    .count(count)
  );
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic summarize();
    $display("TB: %0d errors in %0d comparisons", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus access, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50) begin
      err_count++;
      $display("ERROR %0t: bus timeout", $time);
      summarize();
    end
  endtask
  task automatic wait_frames(input int target);
    int k;
    k = 0;
    while (count < target && k < 5000) begin
      @(posedge clk);
      k++;
    end
    if (count < target) begin
      err_count++;
      $display("ERROR %0t: frame missing", $time);
      summarize();
    end
  endtask
  // line bits after the start bit, first sent in bit 0
  function automatic logic [11:0] frame(input logic [8:0] d, input int w, input logic [1:0] pm,
                                        input logic st);
    int j;
    frame = 12'h000;
    for (j = 0; j < w; j++) frame[j] = d[j];
    if (pm[1]) frame[w] = ^(d & ((9'h1 << w) - 9'h1)) ^ pm[0];
    j = w + pm[1];
    frame[j] = 1'b1;
    frame[j + 1] = st;
  endfunction
  task automatic send(input logic [8:0] d, input logic [2:0] c, input logic [1:0] pm,
                      input logic st);
    int w;
    w = (c == `SFT_CSZ_NINE) ? 9 : 5 + c;
    bus(1'b1, `SFT_ADDR_CTRL_C, {26'h0, pm, st, c[1:0], 1'b0});
    bus(1'b1, `SFT_ADDR_CTRL_B, {27'h0, 2'b01, c[2], 1'b0, d[8]});
    bus(1'b1, `SFT_ADDR_STATUS, 32'h40);
    len = 4'(w + pm[1] + 1 + st);
    bus(1'b1, `SFT_ADDR_DATA, {23'h0, d});
    wait_frames(count + 1);
    chk({20'h0, bits}, {20'h0, frame(d, w, pm, st)});
    repeat (16) @(posedge clk);
    bus(1'b0, `SFT_ADDR_STATUS, 32'h0);
    chk(q, 32'h60);
  endtask
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    len = 4'd9;
    fast = 1'b0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    // an unmapped write that must leave nothing behind, then reset values
    bus(1'b1, 5'h14, 32'hffffffff);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk(q, rv[i]);
    end
    chk({31'h0, txd_oe}, 32'h0);
    bus(1'b1, `SFT_ADDR_CTRL_B, 32'h08);
    repeat (3) @(posedge clk);
    chk({30'h0, txd_oe, txd_out}, 32'h3);
    // every size, parity and stop combination
    for (int i = 0; i < 30; i++) begin
      send(9'h1a5 ^ 9'(i * 37), codes[i % 5], pms[(i / 5) % 3], 1'(i / 15));
    end
    // second byte queued behind a frame in flight
    bus(1'b1, `SFT_ADDR_CTRL_C, 32'h06);
    bus(1'b1, `SFT_ADDR_CTRL_B, 32'h08);
    bus(1'b1, `SFT_ADDR_STATUS, 32'h42);
    len = 4'd9;
    fast = 1'b1;
    c0 = count;
    bus(1'b1, `SFT_ADDR_DATA, 32'h3c);
    n = 0;
    do begin
      bus(1'b0, `SFT_ADDR_STATUS, 32'h0);
      n++;
    end while (q[5] !== 1'b1 && n < 20);
    chk({31'h0, q[5]}, 32'h1);
    bus(1'b1, `SFT_ADDR_DATA, 32'hc3);
    bus(1'b0, `SFT_ADDR_STATUS, 32'h0);
    chk(q, 32'h02);
    wait_frames(c0 + 1);
    chk({20'h0, bits}, {20'h0, frame(9'h03c, 8, 2'b00, 1'b0)});
    // second frame under way: buffer empty, no completion while data was waiting
    repeat (8) @(posedge clk);
    bus(1'b0, `SFT_ADDR_STATUS, 32'h0);
    chk(q, 32'h22);
    wait_frames(c0 + 2);
    chk({20'h0, bits}, {20'h0, frame(9'h0c3, 8, 2'b00, 1'b0)});
    repeat (16) @(posedge clk);
    bus(1'b0, `SFT_ADDR_STATUS, 32'h0);
    chk(q, 32'h62);
    bus(1'b1, `SFT_ADDR_STATUS, 32'h40);
    bus(1'b0, `SFT_ADDR_STATUS, 32'h0);
    chk(q, 32'h20);
    // sync master owns the clock pin and toggles it at the oversample rate
    bus(1'b1, `SFT_ADDR_CTRL_C, 32'hc6);
    repeat (3) @(posedge clk);
    q = {31'h0, sync_clock_pin_out};
    @(posedge clk);
    chk({31'h0, sync_clock_pin_oe}, 32'h1);
    chk(q ^ {31'h0, sync_clock_pin_out}, 32'h1);
    bus(1'b1, `SFT_ADDR_CTRL_C, 32'h06);
    repeat (3) @(posedge clk);
    chk({30'h0, sync_clock_pin_oe, sync_clock_pin_out}, 32'h0);
    // idle transmitter gives the pin back
    bus(1'b1, `SFT_ADDR_CTRL_B, 32'h00);
    repeat (4) @(posedge clk);
    chk({31'h0, txd_oe}, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
